// [smgc_regs.vh]
// Constants for the global MAC control register bank of the switch.
// Assumes inclusion by smgc_top.v only; definitions only, no logic.
// Overview of operation
// - Zero VID takes port default VID when enabled.
// - Storm rate is 11 bits over two registers.
// - Storm rate resets to 0x04A, about one percent.
// - Byte budget per period equals rate times 64.
// - Period 5, 50, 500 ms by link speed.
// - Multicast counted only when exclusion bit clear.
// - PAUSE frames forwarded when pass bit set.
// - Ingress period 16, 64 or 256 ms, reset 01.
// - Egress limiting per queue when mode bit set.
// - Flush bit clears enabled counters, then self-clears.
// - Freeze bit holds enabled counters while set.
// - Flush and freeze act only on enabled ports.
// - Tagged priority from PCP-selected mapping field.
// - PCP 0 and 1 map to 000, 001.
// - PCP 2 and 3 map to 010, 011.
// - PCP 4 and 5 map to 100, 101.
// - PCP 6 and 7 map to 110, 111.
`ifndef SMGC_REGS_VH
`define SMGC_REGS_VH
// Register offsets.
`define SMGC_OFF_MC_EXCL     16'h0331
`define SMGC_OFF_VID_STORM_H 16'h0332
`define SMGC_OFF_STORM_LOW   16'h0333
`define SMGC_OFF_PAUSE_FWD   16'h0334
`define SMGC_OFF_RATE_LIMIT  16'h0335
`define SMGC_OFF_CNT_FLUSH   16'h0336
`define SMGC_OFF_PCP_MAP_01  16'h0338
`define SMGC_OFF_PCP_MAP_23  16'h0339
`define SMGC_OFF_PCP_MAP_45  16'h033A
`define SMGC_OFF_PCP_MAP_67  16'h033B
// Field positions.
`define SMGC_BIT_MC_EXCL     6
`define SMGC_BIT_NULL_VID    3
`define SMGC_BIT_PAUSE_PASS  0
`define SMGC_BIT_QUEUE_MODE  3
`define SMGC_BIT_FLUSH       7
`define SMGC_BIT_FREEZE      6
// Reset values.
`define SMGC_RST_MC_EXCL     1'h1
`define SMGC_RST_VID_HIGH    4'h0
`define SMGC_RST_STORM       11'h04A
`define SMGC_RST_PERIOD      2'h1
`define SMGC_RST_MAP_01      8'h10
`define SMGC_RST_MAP_23      8'h32
`define SMGC_RST_MAP_45      8'h54
`define SMGC_RST_MAP_67      8'h76
// Link speed codes.
`define SMGC_SPD_1000        2'h2
`define SMGC_SPD_100         2'h1
// Timing.
`define SMGC_CLK_NS          40
`define SMGC_STORM_BASE_MS   5
`define SMGC_STORM_BASE_CYC  ((`SMGC_STORM_BASE_MS*1000000)/`SMGC_CLK_NS)
`define SMGC_MS_CYC          (1000000/`SMGC_CLK_NS)
`define SMGC_MULT_100        7'h0A
`define SMGC_MULT_10         7'h64
`define SMGC_ING_P0_MS       9'h010
`define SMGC_ING_P1_MS       9'h040
`define SMGC_ING_P2_MS       9'h100
`endif

// [smgc_top.v]
// Global MAC control registers with the storm, PAUSE, VID and PCP logic.
// Assumes packet descriptors, port speeds and default VIDs arrive on
// clk_sys from switch core logic, so they need no synchronisers.
//
// Our own choice: the plain strobed port.
`timescale 1ns/10ps
`include "smgc_regs.vh"

module smgc_top #(
  parameter NPORTS    = 3,
  parameter STORM_CYC = `SMGC_STORM_BASE_CYC,
  parameter MS_CYC    = `SMGC_MS_CYC
) (
  // Clock and reset.
  input  wire                clk_sys,
  input  wire                rst_n,
  // Register port.
  input  wire [15:0]         reg_addr,
  input  wire [7:0]          reg_wdata,
  input  wire                reg_wr,
  input  wire                reg_rd,
  output reg  [7:0]          reg_rdata_q,
  // Per-port link state.
  input  wire [2*NPORTS-1:0] port_speed,
  input  wire [12*NPORTS-1:0] port_pvid,
  input  wire [NPORTS-1:0]   mib_port_en,
  // Packet descriptor.
  input  wire                pkt_valid,
  input  wire [1:0]          pkt_port,
  input  wire                pkt_tagged,
  input  wire [11:0]         pkt_vid,
  input  wire [2:0]          pkt_pcp,
  input  wire                pkt_bcast,
  input  wire                pkt_mcast,
  input  wire                pkt_pause,
  input  wire [15:0]         pkt_len,
  // Packet verdict.
  output reg                 res_valid_q,
  output reg  [11:0]         res_vid_q,
  output reg  [2:0]          res_prio_q,
  output reg                 res_drop_q,
  // Controls to rate limiters and counters.
  output reg                 ing_period_tick_q,
  output wire                egr_queue_mode,
  output wire [NPORTS-1:0]   mib_flush_port,
  output wire [NPORTS-1:0]   mib_freeze_port
);

  // Register state.
  reg        mc_excl_q;
  reg [3:0]  vid_rsvd_q;
  reg        null_vid_q;
  reg [10:0] storm_rate_q;
  reg        pause_pass_q;
  reg        rl_rsvd_q;
  reg [1:0]  ing_period_q;
  reg        queue_mode_q;
  reg        flush_q;
  reg        freeze_q;
  reg [7:0]  map01_q;
  reg [7:0]  map23_q;
  reg [7:0]  map45_q;
  reg [7:0]  map67_q;
  reg [7:0]  rdata_d;

  // Register writes; the flush bit stands for one cycle only.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mc_excl_q    <= `SMGC_RST_MC_EXCL;
      vid_rsvd_q   <= `SMGC_RST_VID_HIGH;
      null_vid_q   <= 1'b0;
      storm_rate_q <= `SMGC_RST_STORM;
      pause_pass_q <= 1'b0;
      rl_rsvd_q    <= 1'b0;
      ing_period_q <= `SMGC_RST_PERIOD;
      queue_mode_q <= 1'b0;
      flush_q      <= 1'b0;
      freeze_q     <= 1'b0;
      map01_q      <= `SMGC_RST_MAP_01;
      map23_q      <= `SMGC_RST_MAP_23;
      map45_q      <= `SMGC_RST_MAP_45;
      map67_q      <= `SMGC_RST_MAP_67;
    end else begin
      flush_q <= 1'b0;
      if (reg_wr) begin
        case (reg_addr)
          `SMGC_OFF_MC_EXCL: begin
            mc_excl_q <= reg_wdata[`SMGC_BIT_MC_EXCL];
          end
          `SMGC_OFF_VID_STORM_H: begin
            vid_rsvd_q         <= reg_wdata[7:4];
            null_vid_q         <= reg_wdata[`SMGC_BIT_NULL_VID];
            storm_rate_q[10:8] <= reg_wdata[2:0];
          end
          `SMGC_OFF_STORM_LOW: begin
            storm_rate_q[7:0] <= reg_wdata;
          end
          `SMGC_OFF_PAUSE_FWD: begin
            pause_pass_q <= reg_wdata[`SMGC_BIT_PAUSE_PASS];
          end
          `SMGC_OFF_RATE_LIMIT: begin
            rl_rsvd_q    <= reg_wdata[6];
            ing_period_q <= reg_wdata[5:4];
            queue_mode_q <= reg_wdata[`SMGC_BIT_QUEUE_MODE];
          end
          `SMGC_OFF_CNT_FLUSH: begin
            flush_q  <= reg_wdata[`SMGC_BIT_FLUSH];
            freeze_q <= reg_wdata[`SMGC_BIT_FREEZE];
          end
          `SMGC_OFF_PCP_MAP_01: begin
            map01_q <= reg_wdata & 8'h77;
          end
          `SMGC_OFF_PCP_MAP_23: begin
            map23_q <= reg_wdata & 8'h77;
          end
          `SMGC_OFF_PCP_MAP_45: begin
            map45_q <= reg_wdata & 8'h77;
          end
          `SMGC_OFF_PCP_MAP_67: begin
            map67_q <= reg_wdata & 8'h77;
          end
          default: begin
            flush_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // Read mux; reserved read-only bits and unmapped offsets read as zero.
  always @* begin
    rdata_d = 8'h00;
    case (reg_addr)
      `SMGC_OFF_MC_EXCL:     rdata_d = {1'b0, mc_excl_q, 6'h00};
      `SMGC_OFF_VID_STORM_H: rdata_d = {vid_rsvd_q, null_vid_q,
                                        storm_rate_q[10:8]};
      `SMGC_OFF_STORM_LOW:   rdata_d = storm_rate_q[7:0];
      `SMGC_OFF_PAUSE_FWD:   rdata_d = {7'h00, pause_pass_q};
      `SMGC_OFF_RATE_LIMIT:  rdata_d = {1'b0, rl_rsvd_q, ing_period_q,
                                        queue_mode_q, 3'h0};
      `SMGC_OFF_CNT_FLUSH:   rdata_d = {flush_q, freeze_q, 6'h00};
      `SMGC_OFF_PCP_MAP_01:  rdata_d = map01_q;
      `SMGC_OFF_PCP_MAP_23:  rdata_d = map23_q;
      `SMGC_OFF_PCP_MAP_45:  rdata_d = map45_q;
      `SMGC_OFF_PCP_MAP_67:  rdata_d = map67_q;
      default:               rdata_d = 8'h00;
    endcase
  end

  // Read data stands in the cycle after the read strobe only.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_q <= rdata_d;
    end else begin
      reg_rdata_q <= 8'h00;
    end
  end

  // Counter commands, gated per enabled port.
  assign mib_flush_port  = {NPORTS{flush_q}} & mib_port_en;
  assign mib_freeze_port = {NPORTS{freeze_q}} & mib_port_en;
  assign egr_queue_mode  = queue_mode_q;

  // Storm base tick every 5 ms, shared by all ports.
  reg [31:0] base_cnt_q;
  wire       base_tick = (base_cnt_q == STORM_CYC - 1);
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      base_cnt_q <= 32'h00000000;
    end else if (base_tick) begin
      base_cnt_q <= 32'h00000000;
    end else begin
      base_cnt_q <= base_cnt_q + 32'h00000001;
    end
  end

  // Ingress rate-limit period: millisecond ticks counted to 16/64/256.
  reg [31:0] ms_cnt_q;
  reg [8:0]  ing_ms_q;
  reg [8:0]  ing_lim;
  wire       ms_tick = (ms_cnt_q == MS_CYC - 1);
  always @* begin
    case (ing_period_q)
      2'h0:    ing_lim = `SMGC_ING_P0_MS;
      2'h1:    ing_lim = `SMGC_ING_P1_MS;
      default: ing_lim = `SMGC_ING_P2_MS;
    endcase
  end
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt_q          <= 32'h00000000;
      ing_ms_q          <= 9'h000;
      ing_period_tick_q <= 1'b0;
    end else begin
      ing_period_tick_q <= 1'b0;
      if (ms_tick) begin
        ms_cnt_q <= 32'h00000000;
        if (ing_ms_q >= ing_lim - 9'h001) begin
          ing_ms_q          <= 9'h000;
          ing_period_tick_q <= 1'b1;
        end else begin
          ing_ms_q <= ing_ms_q + 9'h001;
        end
      end else begin
        ms_cnt_q <= ms_cnt_q + 32'h00000001;
      end
    end
  end

  // Storm class: broadcast, plus multicast when not excluded.
  wire        storm_cls = pkt_bcast | (pkt_mcast & ~mc_excl_q);
  wire [16:0] budget_full = {storm_rate_q, 6'h00};
  wire [NPORTS-1:0] storm_drop;

  // Per-port period timer and byte budget.
  genvar gi;
  generate
    for (gi = 0; gi < NPORTS; gi = gi + 1) begin : g_port
      reg [6:0]  per_cnt_q;
      reg [6:0]  per_lim;
      reg [16:0] budget_q;
      wire [1:0] spd = port_speed[2*gi+1:2*gi];
      wire       per_end = base_tick && (per_cnt_q >= per_lim - 7'h01);
      wire       hit = pkt_valid && storm_cls && (pkt_port == gi);
      // Base ticks per period by link speed.
      always @* begin
        if (spd == `SMGC_SPD_1000) begin
          per_lim = 7'h01;
        end else if (spd == `SMGC_SPD_100) begin
          per_lim = `SMGC_MULT_100;
        end else begin
          per_lim = `SMGC_MULT_10;
        end
      end
      assign storm_drop[gi] = hit && (budget_q == 17'h00000);
      // Period end restores the budget; hits spend it down to zero.
      always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          per_cnt_q <= 7'h00;
          budget_q  <= {`SMGC_RST_STORM, 6'h00};
        end else begin
          if (per_end) begin
            per_cnt_q <= 7'h00;
            budget_q  <= budget_full;
          end else begin
            if (base_tick) begin
              per_cnt_q <= per_cnt_q + 7'h01;
            end
            if (hit && budget_q != 17'h00000) begin
              if (budget_q > {1'b0, pkt_len}) begin
                budget_q <= budget_q - {1'b0, pkt_len};
              end else begin
                budget_q <= 17'h00000;
              end
            end
          end
        end
      end
    end
  endgenerate

  // Priority lookup from the mapping byte picked by the code point.
  reg [7:0] map_byte;
  reg [2:0] prio_d;
  always @* begin
    case (pkt_pcp[2:1])
      2'h0:    map_byte = map01_q;
      2'h1:    map_byte = map23_q;
      2'h2:    map_byte = map45_q;
      default: map_byte = map67_q;
    endcase
    prio_d = pkt_pcp[0] ? map_byte[6:4] : map_byte[2:0];
    if (!pkt_tagged) begin
      prio_d = 3'h0;
    end
  end

  // Default VID of the ingress port, zero for an unknown port.
  reg [11:0] pvid_sel;
  integer    k;
  always @* begin
    pvid_sel = 12'h000;
    for (k = 0; k < NPORTS; k = k + 1) begin
      if (pkt_port == k) begin
        pvid_sel = port_pvid[12*k +: 12];
      end
    end
  end

  // Verdict one cycle after the descriptor.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      res_valid_q <= 1'b0;
      res_vid_q   <= 12'h000;
      res_prio_q  <= 3'h0;
      res_drop_q  <= 1'b0;
    end else begin
      res_valid_q <= pkt_valid;
      if (pkt_valid) begin
        if (null_vid_q && pkt_vid == 12'h000) begin
          res_vid_q <= pvid_sel;
        end else begin
          res_vid_q <= pkt_vid;
        end
        res_prio_q <= prio_d;
        res_drop_q <= (|storm_drop) | (pkt_pause & ~pause_pass_q);
      end
    end
  end

endmodule // smgc_top

// [smgc_chk.sv]
// Checker of the MAC control bank ports, bound into smgc_top.
// Assumes one clock domain and NPORTS ports as in the design.
`timescale 1ns/10ps

module smgc_chk #(
  parameter NPORTS = 3
) (
  // Clock and reset.
  input wire              clk_sys,
  input wire              rst_n,
  // Register writes and packet requests.
  input wire [15:0]       reg_addr,
  input wire [7:0]        reg_wdata,
  input wire              reg_wr,
  input wire [NPORTS-1:0] mib_port_en,
  input wire              pkt_valid,
  input wire              pkt_tagged,
  input wire              pkt_bcast,
  input wire              pkt_mcast,
  input wire              pkt_pause,
  // Outputs under watch.
  input wire              res_valid_q,
  input wire [2:0]        res_prio_q,
  input wire              res_drop_q,
  input wire              egr_queue_mode,
  input wire [NPORTS-1:0] mib_flush_port,
  input wire [NPORTS-1:0] mib_freeze_port
);
  // Decoded writes to the counter and rate registers.
  wire wr_mib = reg_wr && reg_addr == 16'h0336;
  wire wr_rate = reg_wr && reg_addr == 16'h0335;
  reg  pass_q;

  // Shadow of the PAUSE pass bit, so the verdict can be predicted.
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      pass_q <= 1'b0;
    else if (reg_wr && reg_addr == 16'h0334)
      pass_q <= reg_wdata[0];
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // Each watched control and verdict output is tied to its cause.
  a_flush_pulse: assert property (wr_mib && reg_wdata[7] |=>
    mib_flush_port == mib_port_en) else $error("flush not raised");
  a_flush_once: assert property (mib_flush_port != '0 && !wr_mib |=>
    mib_flush_port == '0) else $error("flush held too long");
  a_freeze_only: assert property (
    (mib_freeze_port & ~mib_port_en) == '0) else $error("idle port frozen");
  a_freeze_set: assert property (wr_mib |=>
    mib_freeze_port == ($past(reg_wdata[6]) ? mib_port_en : '0))
    else $error("freeze not following write");
  a_queue_mode: assert property (wr_rate |=>
    egr_queue_mode == $past(reg_wdata[3])) else $error("queue mode wrong");
  a_res_pulse: assert property (
    res_valid_q == $past(pkt_valid)) else $error("verdict pulse wrong");
  a_pause_drop: assert property (pkt_valid && pkt_pause && !pkt_bcast
    && !pkt_mcast |=> res_drop_q == !pass_q) else $error("PAUSE verdict");
  a_untag_prio: assert property (pkt_valid && !pkt_tagged |=>
    res_prio_q == 3'h0) else $error("untagged priority not zero");
endmodule // smgc_chk

bind smgc_top smgc_chk #(.NPORTS(NPORTS)) smgc_chk_i (
  .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .mib_port_en(mib_port_en),
  .pkt_valid(pkt_valid), .pkt_tagged(pkt_tagged), .pkt_bcast(pkt_bcast),
  .pkt_mcast(pkt_mcast), .pkt_pause(pkt_pause),
  .res_valid_q(res_valid_q), .res_prio_q(res_prio_q),
  .res_drop_q(res_drop_q), .egr_queue_mode(egr_queue_mode),
  .mib_flush_port(mib_flush_port), .mib_freeze_port(mib_freeze_port));

// [smgc_top_tb.sv]
// Self-checking bench of the MAC control bank and its packet verdicts.
// Assumes smgc_top with short storm and millisecond counts.
`timescale 1ns/10ps

module smgc_top_tb;
  // Reset values and tick periods, last entry first.
  localparam [175:0] RA = {16'h0331, 16'h0332, 16'h0333, 16'h0334,
    16'h0335, 16'h0336, 16'h0337, 16'h0338, 16'h0339, 16'h033A, 16'h033B};
  localparam [87:0] RV = {8'h40, 8'h00, 8'h4A, 8'h00, 8'h10, 8'h00,
    8'h00, 8'h10, 8'h32, 8'h54, 8'h76};
  localparam [47:0] PER = {16'h0A00, 16'h0280, 16'h00A0};
  // Stimulus and observed outputs.
  reg         clk_sys = 1'b0;
  reg         rst_n = 1'b0;
  reg  [15:0] reg_addr = 16'h0;
  reg  [7:0]  reg_wdata = 8'h0;
  reg         reg_wr = 1'b0;
  reg         pkt_valid = 1'b0;
  reg  [1:0]  pkt_port = 2'h0;
  reg         pkt_tagged = 1'b0;
  reg  [11:0] pkt_vid = 12'h0;
  reg  [2:0]  pkt_pcp = 3'h0;
  reg  [2:0]  pkt_kind = 3'h0;
  wire [7:0]  reg_rdata_q;
  wire [11:0] res_vid_q;
  wire [2:0]  res_prio_q, mib_flush_port, mib_freeze_port;
  wire        res_valid_q, res_drop_q, tick, egr_queue_mode;
  int         fail_count = 0;
  int         check_count = 0;
  int         n;
  int         cyc = 0;
  reg         reg_rd = 1'b0;
  reg  [2:0]  mib_port_en = 3'h5;
  reg  [15:0] pkt_len = 16'h0064;

  smgc_top #(.NPORTS(3), .STORM_CYC(20), .MS_CYC(10)) smgc_top_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .port_speed(6'h06),
    .port_pvid(36'h000123000), .mib_port_en(mib_port_en),
    .pkt_valid(pkt_valid), .pkt_port(pkt_port), .pkt_tagged(pkt_tagged),
    .pkt_vid(pkt_vid), .pkt_pcp(pkt_pcp), .pkt_bcast(pkt_kind[2]),
    .pkt_mcast(pkt_kind[1]), .pkt_pause(pkt_kind[0]), .pkt_len(pkt_len),
    .res_valid_q(res_valid_q), .res_vid_q(res_vid_q),
    .res_prio_q(res_prio_q), .res_drop_q(res_drop_q),
    .ing_period_tick_q(tick), .egr_queue_mode(egr_queue_mode),
    .mib_flush_port(mib_flush_port), .mib_freeze_port(mib_freeze_port));

  always #20 clk_sys = ~clk_sys;

  // Counts edges since reset release; storm periods end on multiples.
  always @(posedge clk_sys) begin
    if (rst_n)
      cyc <= cyc + 1;
  end

  // Compares one value and counts it.
  task chk(input string what, input [15:0] exp, input [15:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task conclude;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // One register write cycle.
  task wr(input [15:0] a, input [7:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // One read cycle; the data stand in the cycle after the strobe.
  task rd(input [15:0] a, input [7:0] exp);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk("read data", {8'h0, exp}, {8'h0, reg_rdata_q});
  endtask

  // One packet of pkt_len bytes, 100 unless set; kind is broadcast, multicast, PAUSE.
  task pkt(input [1:0] p, input t, input [11:0] v, input [2:0] c,
           input [2:0] k, input drop);
    @(posedge clk_sys);
    pkt_valid  <= 1'b1;
    pkt_port   <= p;
    pkt_tagged <= t;
    pkt_vid    <= v;
    pkt_pcp    <= c;
    pkt_kind   <= k;
    @(posedge clk_sys);
    pkt_valid <= 1'b0;
    #1;
    chk("verdict", 16'h1, {15'h0, res_valid_q});
    chk("drop", {15'h0, drop}, {15'h0, res_drop_q});
  endtask

  // Counts cycles up to the next ingress tick, with a bound.
  task wtick;
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (tick !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      fail_count++;
      conclude;
    end
  endtask

  // Waits until just after a 10 Mbps storm period end, with a bound.
  task walign;
    n = 0;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (cyc % 2000 != 4 && n < 2100);
    if (n >= 2100) begin
      fail_count++;
      conclude;
    end
  endtask

  // Reset values, unmapped read, read-only bits and queue mode.
  task t_regs;
    for (int i = 0; i < 11; i++)
      rd(RA[16*i +: 16], RV[8*i +: 8]);
    wr(16'h0338, 8'hFF);
    rd(16'h0338, 8'h77);
    wr(16'h0335, 8'hFF);
    rd(16'h0335, 8'h78);
    chk("queue mode", 16'h1, {15'h0, egr_queue_mode});
    wr(16'h0335, 8'h10);
    #1;
    chk("queue mode", 16'h0, {15'h0, egr_queue_mode});
    wr(16'h0338, 8'h10);
    $display("test registers done");
  endtask

  // Priority of every code point, then a remapped byte.
  task t_prio;
    for (int c = 0; c < 8; c++) begin
      pkt(2'h0, 1'b1, 12'h005, c[2:0], 3'h0, 1'b0);
      chk("priority", c, {13'h0, res_prio_q});
    end
    wr(16'h033A, 8'h27);
    pkt(2'h0, 1'b1, 12'h005, 3'h4, 3'h0, 1'b0);
    chk("priority", 16'h7, {13'h0, res_prio_q});
    pkt(2'h0, 1'b1, 12'h005, 3'h5, 3'h0, 1'b0);
    chk("priority", 16'h2, {13'h0, res_prio_q});
    wr(16'h033A, 8'h54);
    $display("test priority done");
  endtask

  // Null VID replacement and PAUSE filtering.
  task t_vid;
    pkt(2'h1, 1'b1, 12'h000, 3'h0, 3'h0, 1'b0);
    chk("vid", 16'h0, {4'h0, res_vid_q});
    wr(16'h0332, 8'h08);
    pkt(2'h1, 1'b1, 12'h000, 3'h0, 3'h0, 1'b0);
    chk("vid", 16'h123, {4'h0, res_vid_q});
    pkt(2'h1, 1'b1, 12'h456, 3'h3, 3'h0, 1'b0);
    chk("vid", 16'h456, {4'h0, res_vid_q});
    wr(16'h0332, 8'h00);
    pkt(2'h0, 1'b0, 12'h001, 3'h0, 3'h1, 1'b1);
    wr(16'h0334, 8'h01);
    pkt(2'h0, 1'b0, 12'h001, 3'h0, 3'h1, 1'b0);
    wr(16'h0334, 8'h00);
    $display("test vid and pause done");
  endtask

  // Flush pulse and freeze level on enabled ports only.
  task t_mib;
    wr(16'h0336, 8'hC0);
    #1;
    chk("flush", 16'h5, {13'h0, mib_flush_port});
    chk("freeze", 16'h5, {13'h0, mib_freeze_port});
    rd(16'h0336, 8'h40);
    chk("flush", 16'h0, {13'h0, mib_flush_port});
    wr(16'h0336, 8'h00);
    #1;
    chk("freeze", 16'h0, {13'h0, mib_freeze_port});
    mib_port_en <= 3'h2;
    wr(16'h0336, 8'h40);
    #1;
    chk("freeze", 16'h2, {13'h0, mib_freeze_port});
    wr(16'h0336, 8'h00);
    mib_port_en <= 3'h5;
    for (int k = 0; k < 3; k++) begin
      wr(16'h0335, {2'h0, k[1:0], 4'h0});
      wtick;
      wtick;
      chk("tick period", PER[16*k +: 16], n[15:0]);
    end
    wr(16'h0335, 8'h10);
    $display("test counters and ticks done");
  endtask

  // Storm budget of 128 bytes on the 10 Mbps port.
  task t_storm;
    wr(16'h0333, 8'h02);
    walign;
    pkt(2'h2, 1'b0, 12'h001, 3'h0, 3'h4, 1'b0);
    pkt(2'h2, 1'b0, 12'h001, 3'h0, 3'h4, 1'b0);
    pkt(2'h2, 1'b0, 12'h001, 3'h0, 3'h4, 1'b1);
    pkt(2'h2, 1'b0, 12'h001, 3'h0, 3'h2, 1'b0);
    wr(16'h0331, 8'h00);
    pkt(2'h2, 1'b0, 12'h001, 3'h0, 3'h2, 1'b1);
    repeat (25) @(posedge clk_sys);
    pkt(2'h2, 1'b0, 12'h001, 3'h0, 3'h4, 1'b1);
    walign;
    pkt_len <= 16'h00C8;
    pkt(2'h2, 1'b0, 12'h001, 3'h0, 3'h4, 1'b0);
    pkt(2'h2, 1'b0, 12'h001, 3'h0, 3'h4, 1'b1);
    pkt_len <= 16'h0064;
    wr(16'h0331, 8'h40);
    wr(16'h0333, 8'h4A);
    $display("test storm done");
  endtask

  // Main sequence.
  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_regs;
    t_prio;
    t_vid;
    t_mib;
    t_storm;
    conclude;
  end
endmodule // smgc_top_tb
